// ==== logic/bbe_cfg.svh ====
// bbe_cfg.svh: register map, field positions and sizes of the beam
// blanking evaluator, as text macros.
// assumes: included by bare name from every file of the block.
`ifndef BBE_CFG_SVH
`define BBE_CFG_SVH

// curtain geometry and area slots
`define BBE_BEAMS 32
`define BBE_AREAS 4
`define BBE_AW 2
`define BBE_AREA_W 21

// register byte addresses on the plain register port
`define BBE_ADDR_CTRL 8'h00
`define BBE_ADDR_STAT 8'h04
`define BBE_ADDR_IRQ_STAT 8'h08
`define BBE_ADDR_IRQ_EN 8'h0C
`define BBE_ADDR_IRQ_CLR 8'h10
`define BBE_AREA_PAGE 4'h2

// control register fields
`define BBE_CTRL_W 5
`define BBE_CTRL_RED_EN 0
`define BBE_CTRL_CNT_LO 1
`define BBE_CTRL_CNT_HI 2
`define BBE_CTRL_PHY_LO 3
`define BBE_CTRL_PHY_HI 4

// physical resolution codes
`define BBE_PHYS_14 2'h0
`define BBE_PHYS_20 2'h1

// area word fields
`define BBE_AR_START_LO 0
`define BBE_AR_START_HI 4
`define BBE_AR_SIZE_LO 5
`define BBE_AR_SIZE_HI 9
`define BBE_AR_END_LO 10
`define BBE_AR_END_HI 14
`define BBE_AR_PTOL_LO 15
`define BBE_AR_PTOL_HI 16
`define BBE_AR_STOL1 17
`define BBE_AR_FTOL2 18
`define BBE_AR_FLOAT 19
`define BBE_AR_EN 20

// limits
`define BBE_PTOL_MAX 2
`define BBE_FLOAT_MIN 2
`define BBE_RED_MAX_20 2

// interrupt status bits
`define BBE_IRQ_W 3
`define BBE_EV_RED 0
`define BBE_EV_GREEN 1
`define BBE_EV_CFG 2

`endif

// ==== logic/bbe_pkg.sv ====
// bbe_pkg: types of the beam blanking evaluator.
// assumes: bbe_cfg.svh is on the include path.
`include "bbe_cfg.svh"

package bbe_pkg;

	// evaluation sequencer, one-hot
	typedef enum logic [2:0] {
		BBE_IDLE = 3'h1,
		BBE_EVAL = 3'h2,
		BBE_DECIDE = 3'h4
	} bbe_state_t;

	// whole state of the evaluator
	typedef struct packed {
		bbe_state_t st;
		logic [`BBE_BEAMS-1:0] blk;
		logic [`BBE_BEAMS-1:0] covered;
		logic fail;
		logic cfg_bad;
		logic [`BBE_AW-1:0] idx;
		logic green;
		logic cfg_err;
		logic [`BBE_CTRL_W-1:0] ctrl;
		logic [`BBE_IRQ_W-1:0] irq_stat;
		logic [`BBE_IRQ_W-1:0] irq_en;
		logic [31:0] rdata;
		logic area_rd;
	} bbe_state_s_t;

endpackage : bbe_pkg

// ==== logic/bbe_area_mem.sv ====
// bbe_area_mem: the four blanked-area descriptors.
// assumes: one clock, synchronous reset; read data is registered.
`timescale 1ns/1ps
`default_nettype none
`include "bbe_cfg.svh"

module bbe_area_mem (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// write port
	input wire logic wr_en,
	input wire logic [`BBE_AW-1:0] wr_addr,
	input wire logic [`BBE_AREA_W-1:0] wr_data,
	// read port for the evaluator
	input wire logic [`BBE_AW-1:0] a_addr,
	output logic [`BBE_AREA_W-1:0] a_data,
	// read port for software
	input wire logic [`BBE_AW-1:0] b_addr,
	output logic [`BBE_AREA_W-1:0] b_data
);

	logic [`BBE_AREA_W-1:0] mem [`BBE_AREAS];

	// cleared at reset so no area is enabled by accident
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < `BBE_AREAS; i++) begin
				mem[i] <= '0;
			end
			a_data <= '0;
			b_data <= '0;
		end else begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			a_data <= mem[a_addr];
			b_data <= mem[b_addr];
		end
	end

endmodule : bbe_area_mem
`default_nettype wire

// ==== logic/bbe_eval.sv ====
// bbe_eval: per-scan evaluation of blanked areas and reduced resolution,
// deciding the green or red state of the protective field.
// assumes: one scan vector per scan_valid pulse, beam 0 is the sync beam;
// registers reached over a plain strobe port, read data one cycle later.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "bbe_cfg.svh"

// Behaviour
// - up to four blanked areas, fixed and floating together
// - an area touching the sync beam is rejected, forcing red
// - fixed area may shift up to two beams either way
// - fixed area may optionally be one beam smaller
// - fixed area clear beyond tolerance drives red
// - floating group of two or more beams may move freely
// - floating group absent drives red
// - each area evaluated by its own type
// - floating size tolerance of one or two beams
// - two-beam floating tolerance only on 14 or 20 mm units
// - reduced resolution tolerates one to three adjacent beams
// - reduced resolution only on 14/20 mm, three beams not on 20
// - sync beam interrupted always drives red
// - evaluation takes the same cycles with reduced resolution
module bbe_eval (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// optical front end
	input wire logic scan_valid,
	input wire logic [`BBE_BEAMS-1:0] beam_blocked,
	// safety outputs
	output logic field_green,
	output logic field_red,
	output logic eval_busy,
	// interrupt
	output logic irq
);

	bbe_pkg::bbe_state_s_t s;
	bbe_pkg::bbe_state_s_t next_s;

	logic [`BBE_AW-1:0] mem_a_addr;
	logic [`BBE_AREA_W-1:0] area;
	logic [`BBE_AREA_W-1:0] mem_b_data;
	logic area_sel;
	logic [`BBE_BEAMS-1:0] win;
	logic [`BBE_BEAMS-1:0] seen;
	logic [`BBE_BEAMS-1:0] unc;
	logic ctrl_bad;
	logic area_ok;
	logic area_bad;
	logic red_now;
	logic [`BBE_IRQ_W-1:0] ev;
	logic [`BBE_IRQ_W-1:0] clr;
	int lo;
	int hi;
	int sz;
	int tol;
	int n;

	// mask of beams lo..hi inclusive
	function automatic logic [`BBE_BEAMS-1:0] win_mask(input int l,
		input int h);
		logic [`BBE_BEAMS-1:0] m;
		m = '0;
		for (int i = 0; i < `BBE_BEAMS; i++) begin
			if (i >= l && i <= h) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction : win_mask

	// number of blocked beams
	function automatic int ones(input logic [`BBE_BEAMS-1:0] v);
		int c;
		c = 0;
		for (int i = 0; i < `BBE_BEAMS; i++) begin
			c = c + int'(v[i]);
		end
		return c;
	endfunction : ones

	// number of separate blocked groups
	function automatic int groups(input logic [`BBE_BEAMS-1:0] v);
		int c;
		c = int'(v[0]);
		for (int i = 1; i < `BBE_BEAMS; i++) begin
			c = c + int'(v[i] & ~v[i-1]);
		end
		return c;
	endfunction : groups

	// longest run of adjacent blocked beams
	function automatic int longest(input logic [`BBE_BEAMS-1:0] v);
		int c;
		int m;
		c = 0;
		m = 0;
		for (int i = 0; i < `BBE_BEAMS; i++) begin
			c = v[i] ? c + 1 : 0;
			m = (c > m) ? c : m;
		end
		return m;
	endfunction : longest

	// evaluator reads the next slot while judging the current one
	assign mem_a_addr = (s.st == bbe_pkg::BBE_IDLE) ? '0 :
		`BBE_AW'(s.idx + 2'h1);
	assign area_sel = reg_addr[7:4] == `BBE_AREA_PAGE &&
		reg_addr[1:0] == 2'h0;

	bbe_area_mem u_mem (
		.core_clk(core_clk),
		.rst(rst),
		.wr_en(reg_wr && area_sel),
		.wr_addr(reg_addr[3:2]),
		.wr_data(reg_wdata[`BBE_AREA_W-1:0]),
		.a_addr(mem_a_addr),
		.a_data(area),
		.b_addr(reg_addr[3:2]),
		.b_data(mem_b_data)
	);

	// reduced resolution option check against the unit's optics
	always_comb begin
		ctrl_bad = 1'b0;
		if (s.ctrl[`BBE_CTRL_RED_EN]) begin
			if (s.ctrl[`BBE_CTRL_PHY_HI:`BBE_CTRL_PHY_LO] != `BBE_PHYS_14 &&
				s.ctrl[`BBE_CTRL_PHY_HI:`BBE_CTRL_PHY_LO] != `BBE_PHYS_20) begin
				ctrl_bad = 1'b1;
			end
			if (s.ctrl[`BBE_CTRL_CNT_HI:`BBE_CTRL_CNT_LO] == 2'h0) begin
				ctrl_bad = 1'b1;
			end
			if (s.ctrl[`BBE_CTRL_PHY_HI:`BBE_CTRL_PHY_LO] == `BBE_PHYS_20 &&
				int'(s.ctrl[`BBE_CTRL_CNT_HI:`BBE_CTRL_CNT_LO]) >
				`BBE_RED_MAX_20) begin
				ctrl_bad = 1'b1;
			end
		end
	end

	// judge the area descriptor that arrived this cycle
	always_comb begin
		sz = int'(area[`BBE_AR_SIZE_HI:`BBE_AR_SIZE_LO]);
		lo = 0;
		hi = 0;
		tol = 0;
		area_bad = 1'b0;
		if (area[`BBE_AR_FLOAT]) begin
			// floating: any position inside its travel range
			lo = int'(area[`BBE_AR_START_HI:`BBE_AR_START_LO]);
			hi = int'(area[`BBE_AR_END_HI:`BBE_AR_END_LO]);
			tol = area[`BBE_AR_FTOL2] ? 2 : 1;
			if (area[`BBE_AR_FTOL2] &&
				s.ctrl[`BBE_CTRL_PHY_HI:`BBE_CTRL_PHY_LO] != `BBE_PHYS_14 &&
				s.ctrl[`BBE_CTRL_PHY_HI:`BBE_CTRL_PHY_LO] != `BBE_PHYS_20) begin
				area_bad = 1'b1;
			end
			if (sz < `BBE_FLOAT_MIN || hi < lo) begin
				area_bad = 1'b1;
			end
		end else begin
			// fixed: window widened by the position tolerance
			lo = int'(area[`BBE_AR_START_HI:`BBE_AR_START_LO]) -
				int'(area[`BBE_AR_PTOL_HI:`BBE_AR_PTOL_LO]);
			hi = int'(area[`BBE_AR_START_HI:`BBE_AR_START_LO]) + sz - 1 +
				int'(area[`BBE_AR_PTOL_HI:`BBE_AR_PTOL_LO]);
			tol = int'(area[`BBE_AR_STOL1]);
			if (int'(area[`BBE_AR_PTOL_HI:`BBE_AR_PTOL_LO]) >
				`BBE_PTOL_MAX || sz == 0) begin
				area_bad = 1'b1;
			end
		end
		// the sync beam can never be part of a blanked area
		if (lo <= 0) begin
			area_bad = 1'b1;
		end
		if (hi > `BBE_BEAMS - 1) begin
			hi = `BBE_BEAMS - 1;
		end
		win = win_mask(lo, hi);
		seen = s.blk & win;
		n = ones(seen);
		// one group, no larger than configured, shrunk by the tolerance
		area_ok = n >= sz - tol && n <= sz && groups(seen) <= 1;
		// an emptied window never passes, even a one-beam area with -1
		if (n == 0) begin
			area_ok = 1'b0;
		end
		if (area[`BBE_AR_FLOAT] && n < `BBE_FLOAT_MIN) begin
			area_ok = 1'b0;
		end
	end

	// final verdict over the beams no valid area accounts for
	always_comb begin
		unc = s.blk & ~s.covered;
		red_now = s.fail || s.cfg_bad || ctrl_bad;
		if (s.blk[0]) begin
			red_now = 1'b1;
		end
		if (s.ctrl[`BBE_CTRL_RED_EN]) begin
			if (longest(unc) >
				int'(s.ctrl[`BBE_CTRL_CNT_HI:`BBE_CTRL_CNT_LO])) begin
				red_now = 1'b1;
			end
		end else if (unc != '0) begin
			red_now = 1'b1;
		end
	end

	// interrupt events and software clears
	always_comb begin
		ev = '0;
		if (s.st == bbe_pkg::BBE_DECIDE) begin
			ev[`BBE_EV_RED] = red_now && s.green;
			ev[`BBE_EV_GREEN] = !red_now && !s.green;
			ev[`BBE_EV_CFG] = (s.cfg_bad || ctrl_bad) && !s.cfg_err;
		end
		clr = '0;
		if (reg_wr && reg_addr == `BBE_ADDR_IRQ_CLR) begin
			clr = reg_wdata[`BBE_IRQ_W-1:0];
		end
	end

	// next state: sequencer plus register file
	always_comb begin
		next_s = s;
		next_s.area_rd = 1'b0;
		case (s.st)
			bbe_pkg::BBE_IDLE: begin
				if (scan_valid) begin
					next_s.blk = beam_blocked;
					next_s.covered = '0;
					next_s.fail = 1'b0;
					next_s.cfg_bad = 1'b0;
					next_s.idx = '0;
					next_s.st = bbe_pkg::BBE_EVAL;
				end
			end
			bbe_pkg::BBE_EVAL: begin
				// every slot visited, each by its own type
				if (area[`BBE_AR_EN]) begin
					if (area_bad) begin
						next_s.cfg_bad = 1'b1;
					end
					if (area_ok) begin
						next_s.covered = s.covered | win;
					end else begin
						next_s.fail = 1'b1;
					end
				end
				next_s.idx = `BBE_AW'(s.idx + 2'h1);
				if (s.idx == `BBE_AW'(`BBE_AREAS - 1)) begin
					next_s.st = bbe_pkg::BBE_DECIDE;
				end
			end
			bbe_pkg::BBE_DECIDE: begin
				// same path length whatever the mode
				next_s.green = !red_now;
				next_s.cfg_err = s.cfg_bad || ctrl_bad;
				next_s.st = bbe_pkg::BBE_IDLE;
			end
			default: begin
				next_s.st = bbe_pkg::BBE_IDLE;
				next_s.green = 1'b0;
			end
		endcase
		// set wins over a clear in the same cycle
		next_s.irq_stat = (s.irq_stat & ~clr) | ev;
		if (reg_wr) begin
			if (reg_addr == `BBE_ADDR_CTRL) begin
				next_s.ctrl = reg_wdata[`BBE_CTRL_W-1:0];
			end
			if (reg_addr == `BBE_ADDR_IRQ_EN) begin
				next_s.irq_en = reg_wdata[`BBE_IRQ_W-1:0];
			end
		end
		next_s.rdata = '0;
		if (reg_rd) begin
			next_s.area_rd = area_sel;
			case (reg_addr)
				`BBE_ADDR_CTRL: begin
					next_s.rdata[`BBE_CTRL_W-1:0] = s.ctrl;
				end
				`BBE_ADDR_STAT: begin
					next_s.rdata[2:0] = {s.st != bbe_pkg::BBE_IDLE,
						s.cfg_err, s.green};
				end
				`BBE_ADDR_IRQ_STAT: begin
					next_s.rdata[`BBE_IRQ_W-1:0] = s.irq_stat;
				end
				`BBE_ADDR_IRQ_EN: begin
					next_s.rdata[`BBE_IRQ_W-1:0] = s.irq_en;
				end
				default: begin
					next_s.rdata = '0;
				end
			endcase
		end
	end

	// state register; red from reset until a scan proves the field free
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s <= '0;
			s.st <= bbe_pkg::BBE_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// outputs; area reads come straight from the memory's data register
	assign reg_rdata = s.area_rd ?
		{{(32-`BBE_AREA_W){1'b0}}, mem_b_data} : s.rdata;
	assign field_green = s.green;
	assign field_red = !s.green;
	assign eval_busy = s.st != bbe_pkg::BBE_IDLE;
	assign irq = |(s.irq_stat & s.irq_en);

endmodule : bbe_eval
`default_nettype wire

// ==== verif/bbe_mach_model.sv ====
// bbe_mach_model: machine control behind the two switch outputs.
// assumes: outputs come straight from bbe_eval.
`timescale 1ns/1ps
`default_nettype none

module bbe_mach_model (
	// switch outputs
	input wire logic field_green,
	input wire logic field_red,
	// machine may move
	output logic machine_run
);
	// both must agree, so a stuck pair stops the machine
	assign machine_run = field_green && !field_red;
endmodule : bbe_mach_model
`default_nettype wire

// ==== verif/bbe_eval_assertions.sv ====
// bbe_eval_assertions: port timing checks of the evaluator.
// assumes: bound to bbe_eval, one clock, sync reset high.
`timescale 1ns/1ps
`default_nettype none
`include "bbe_cfg.svh"

module bbe_eval_chk (
	// clock, reset, register port
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// scan and outputs
	input wire logic scan_valid,
	input wire logic [`BBE_BEAMS-1:0] beam_blocked,
	input wire logic field_green,
	input wire logic field_red,
	input wire logic eval_busy,
	input wire logic irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// a scan counts only when taken while idle
	logic take;
	assign take = scan_valid && !eval_busy;

	a_red_inverse: assert property (field_red == !field_green)
		else $error("red not inverse of green");
	a_sync_red: assert property (take && beam_blocked[0] |-> ##6 field_red)
		else $error("sync beam did not force red");
	a_fixed_time: assert property (take |=> eval_busy [*5] ##1 !eval_busy)
		else $error("evaluation length wrong");
	a_busy_cause: assert property ($rose(eval_busy) |-> $past(scan_valid))
		else $error("busy without scan");
	a_verdict_only: assert property ($changed(field_green) |-> $past(take, 6))
		else $error("field changed off verdict");
	a_irq_cause: assert property ($rose(irq) |-> $past(reg_wr) || $past(take, 6))
		else $error("irq rose without cause");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
	a_unmapped_rd: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_clear: assert property (reg_wr && reg_addr == `BBE_ADDR_IRQ_CLR &&
		reg_wdata[2:0] == 3'h7 && !eval_busy |=> !irq)
		else $error("irq stayed after full clear");
	a_status_read: assert property (reg_rd && reg_addr == `BBE_ADDR_STAT |=>
		reg_rdata[0] == $past(field_green) && reg_rdata[2] == $past(eval_busy))
		else $error("status read mismatch");

	c_sync: cover property (take && beam_blocked[0]);
	c_clear: cover property (take && beam_blocked == 32'h0);
	c_irq: cover property ($rose(irq));
endmodule : bbe_eval_chk

bind bbe_eval bbe_eval_chk u_chk (.core_clk, .rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .scan_valid, .beam_blocked, .field_green,
	.field_red, .eval_busy, .irq);
`default_nettype wire

// ==== verif/tb.sv ====
// tb: register and scan tests of the beam blanking evaluator.
// assumes: checker bound by its own file; 100 ns clock.
`timescale 1ns/1ps
`default_nettype none
`include "bbe_cfg.svh"

module tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic scan_valid = 1'b0;
	logic [31:0] beam_blocked = 32'h0;
	logic [31:0] reg_rdata;
	logic field_green, field_red, eval_busy, irq, machine_run;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;

	bbe_eval dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .scan_valid, .beam_blocked, .field_green, .field_red,
		.eval_busy, .irq);
	bbe_mach_model u_mach (.field_green, .field_red, .machine_run);

	// clock
	always #50 core_clk = ~core_clk;

	task automatic end_of_test();
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// data is looked at in its one valid cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd

	// verdict judged through the machine side
	task automatic scan(input logic [31:0] b, input logic g);
		int i;
		@(posedge core_clk);
		scan_valid <= 1'b1;
		beam_blocked <= b;
		@(posedge core_clk);
		scan_valid <= 1'b0;
		#1;
		for (i = 0; i < 20 && eval_busy !== 1'b0; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk({31'h0, machine_run}, {31'h0, g});
	endtask : scan

	// area word: flags are enable, floating, float tol 2, size tol
	function automatic logic [31:0] mk(int s, int z, int e, int p,
		logic [3:0] f);
		return {11'h0, f, p[1:0], e[4:0], z[4:0], s[4:0]};
	endfunction : mk

	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		rd(`BBE_ADDR_STAT, 32'h0);
		rd(`BBE_ADDR_CTRL, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h14, 32'h0);
		scan(32'h0, 1'b1);
		scan(32'h20, 1'b0);
		scan(32'h1, 1'b0);
		wr(`BBE_ADDR_CTRL, 32'h5);
		scan(32'h00300000, 1'b1);
		scan(32'h00700000, 1'b0);
		scan(32'h1, 1'b0);
		wr(`BBE_ADDR_CTRL, 32'h7);
		scan(32'h00700000, 1'b1);
		scan(32'h00F00000, 1'b0);
		wr(`BBE_ADDR_CTRL, 32'hD);
		scan(32'h00300000, 1'b1);
		wr(`BBE_ADDR_CTRL, 32'hF);
		scan(32'h0, 1'b0);
		rd(`BBE_ADDR_STAT, 32'h2);
		wr(`BBE_ADDR_CTRL, 32'h15);
		scan(32'h0, 1'b0);
		wr(`BBE_ADDR_CTRL, 32'h0);
		scan(32'h0, 1'b1);
		wr(`BBE_ADDR_IRQ_CLR, 32'h7);
		scan(32'h8, 1'b0);
		rd(`BBE_ADDR_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(`BBE_ADDR_IRQ_EN, 32'h1);
		@(posedge core_clk);
		#1;
		chk({31'h0, irq}, 32'h1);
		wr(`BBE_ADDR_IRQ_CLR, 32'h1);
		@(posedge core_clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		rd(`BBE_ADDR_IRQ_STAT, 32'h0);
		wr(8'h20, mk(10, 3, 0, 2, 4'b1001));
		scan(32'h1C00, 1'b1);
		scan(32'h7000, 1'b1);
		scan(32'hE000, 1'b0);
		scan(32'h0C00, 1'b1);
		scan(32'h0, 1'b0);
		wr(8'h24, mk(20, 3, 28, 0, 4'b1100));
		scan(32'h1C001C00, 1'b1);
		scan(32'h1C00, 1'b0);
		wr(8'h28, mk(2, 1, 0, 0, 4'b1000));
		wr(8'h2C, mk(5, 2, 0, 0, 4'b1000));
		rd(8'h2C, mk(5, 2, 0, 0, 4'b1000));
		scan(32'h07001C64, 1'b1);
		wr(8'h28, mk(1, 1, 0, 2, 4'b1000));
		scan(32'h07001C62, 1'b0);
		rd(`BBE_ADDR_STAT, 32'h2);
		wr(8'h28, mk(2, 1, 0, 0, 4'b1000));
		wr(8'h24, mk(20, 3, 28, 0, 4'b1110));
		wr(`BBE_ADDR_CTRL, 32'h10);
		scan(32'h07001C64, 1'b0);
		wr(`BBE_ADDR_CTRL, 32'h8);
		scan(32'h07001C64, 1'b1);
		scan(32'h03001C64, 1'b1);
		wr(`BBE_ADDR_IRQ_CLR, 32'h7);
		wr(`BBE_ADDR_CTRL, 32'h1);
		scan(32'h07001C64, 1'b0);
		rd(`BBE_ADDR_IRQ_STAT, 32'h5);
		wr(`BBE_ADDR_CTRL, 32'h8);
		wr(8'h20, mk(10, 3, 0, 3, 4'b1001));
		scan(32'h07001C64, 1'b0);
		wr(8'h20, mk(10, 3, 0, 2, 4'b1001));
		wr(8'h24, mk(20, 1, 28, 0, 4'b1100));
		scan(32'h07001C64, 1'b0);
		wr(8'h24, mk(20, 3, 28, 0, 4'b1110));
		scan(32'h07001C64, 1'b1);
		rd(`BBE_ADDR_IRQ_STAT, 32'h7);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
